// *** core/fl_consts.svh ***
// Pin timing, status bit positions and command byte for the flash host
`ifndef FL_CONSTS_SVH
`define FL_CONSTS_SVH

// ==========================================================
// Clock
`define FL_CLK_NS 4

// ==========================================================
// Bus cycle times (ns), least times rounded up to cycles
`define FL_T_ACC_NS 70
`define FL_T_WP_NS 35
`define FL_T_REC_NS 30
`define FL_T_ACC_CYC ((`FL_T_ACC_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_T_WP_CYC ((`FL_T_WP_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_T_REC_CYC ((`FL_T_REC_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)

// ==========================================================
// Status bit positions in the data byte
`define FL_BIT_POLL 7
`define FL_BIT_TOGGLE 6
`define FL_BIT_FAIL 5
`define FL_BIT_WINDOW 3
`define FL_BIT_SECT 2

// ==========================================================
// Command byte that returns the device to array reads
`define FL_RESET_CMD 8'hf0

`endif

// *** core/fl_pkg.sv ***
// Types shared by the flash host modules
package fl_pkg;

    // User command kinds
    typedef enum logic [2:0] {
        FL_CMD_WRITE,
        FL_CMD_READ,
        FL_CMD_POLL,
        FL_CMD_ERASE_ADD
    } fl_cmd_t;

    // Outcome of a user command
    typedef enum logic [2:0] {
        FL_RES_OK,
        FL_RES_FAIL,
        FL_RES_BUSY,
        FL_RES_REFUSED,
        FL_RES_LOST
    } fl_res_t;

endpackage : fl_pkg

// *** core/fl_bus_cycle.sv ***
// One read or write cycle on the flash pins
`timescale 1ns/1ns
`include "fl_consts.svh"

module fl_bus_cycle (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Cycle request
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [19:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_done,
    output logic [7:0] o_rdata,
    // Flash pins
    output logic [19:0] o_fl_addr,
    input wire logic [7:0] i_fl_data,
    output logic [7:0] o_fl_data,
    output logic o_fl_data_oe,
    output logic o_fl_ce_n,
    output logic o_fl_oe_n,
    output logic o_fl_we_n
);

    typedef enum logic [1:0] {B_IDLE, B_SET, B_ACT, B_REC} fl_bst_t;

    fl_bst_t st_q;
    logic [4:0] cnt_q;
    logic wr_q;

    // ==========================================================
    // Cycle sequencer: setup, strobe, recovery
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_q <= B_IDLE;
            cnt_q <= 5'h00;
            wr_q <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 8'h00;
            o_fl_addr <= 20'h00000;
            o_fl_data <= 8'h00;
            o_fl_data_oe <= 1'b0;
            o_fl_ce_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_fl_we_n <= 1'b1;
        end
        else
        begin
            o_done <= 1'b0;
            case (st_q)
                B_IDLE:
                begin
                    if (i_start)
                    begin
                        st_q <= B_SET;
                        wr_q <= i_write;
                        o_fl_addr <= i_addr;
                        o_fl_data <= i_wdata;
                        o_fl_data_oe <= i_write;
                        o_fl_ce_n <= 1'b0;
                    end
                end
                B_SET:
                begin
                    st_q <= B_ACT;
                    o_fl_we_n <= !wr_q;
                    o_fl_oe_n <= wr_q;
                    cnt_q <= wr_q ? 5'(`FL_T_WP_CYC) : 5'(`FL_T_ACC_CYC);
                end
                B_ACT:
                begin
                    if (cnt_q == 5'h01)
                    begin
                        if (!wr_q)
                            o_rdata <= i_fl_data;
                        o_fl_we_n <= 1'b1;
                        o_fl_oe_n <= 1'b1;
                        o_fl_ce_n <= 1'b1;
                        cnt_q <= 5'(`FL_T_REC_CYC);
                        st_q <= B_REC;
                    end
                    else
                        cnt_q <= cnt_q - 5'h01;
                end
                default:
                begin
                    o_fl_data_oe <= 1'b0;
                    if (cnt_q == 5'h01)
                    begin
                        o_done <= 1'b1;
                        st_q <= B_IDLE;
                    end
                    else
                        cnt_q <= cnt_q - 5'h01;
                end
            endcase
        end
    end

    // Write strobe stays low for at least eight clocks once it falls
    AST_WE_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $fell(o_fl_we_n) |-> !o_fl_we_n [*8])
        else $error("write strobe too short");

endmodule : fl_bus_cycle

// *** core/fl_poll_host.sv ***
// Host controller: flash writes, reads and write-status polling
`timescale 1ns/1ns
`include "fl_consts.svh"

module fl_poll_host #(
    parameter logic [7:0] RESET_CMD = `FL_RESET_CMD
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // User command port
    input wire logic i_cmd_valid,
    input wire fl_pkg::fl_cmd_t i_cmd,
    input wire logic [19:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_keep_polling,
    input wire logic i_skip_window,
    output logic o_cmd_ready,
    output logic o_done,
    output fl_pkg::fl_res_t o_result,
    output logic [7:0] o_rdata,
    output logic o_dev_busy,
    // Flash pins
    output logic [19:0] o_fl_addr,
    input wire logic [7:0] i_fl_data,
    output logic [7:0] o_fl_data,
    output logic o_fl_data_oe,
    output logic o_fl_ce_n,
    output logic o_fl_oe_n,
    output logic o_fl_we_n,
    input wire logic i_fl_ready_busy
);

    typedef enum logic [3:0] {
        S_IDLE, S_WR, S_RD, S_P1, S_P2, S_P3, S_PDATA, S_RST,
        S_E_PRE, S_E_WR, S_E_A, S_E_B, S_END
    } fl_st_t;

    fl_st_t st_q, st_d;
    fl_pkg::fl_res_t res_d;
    logic [19:0] addr_q;
    logic [7:0] wdata_q, first_q, bc_rdata, cyc_wdata;
    logic go_q, keep_q, skip_q, bc_done, cyc_wr, tog_same;
    logic [3:0] rd_cnt_q;
    logic rst_wr_q, fail_seen_q, pre_q, is_poll_q;

    // ==========================================================
    // Cycle engine
    assign cyc_wr = (st_q == S_WR) || (st_q == S_RST) || (st_q == S_E_WR);
    assign cyc_wdata = (st_q == S_RST) ? RESET_CMD : wdata_q;
    assign tog_same = bc_rdata[`FL_BIT_TOGGLE] == first_q[`FL_BIT_TOGGLE];

    fl_bus_cycle u_cyc (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_start(go_q), .i_write(cyc_wr),
        .i_addr(addr_q),
        .i_wdata(cyc_wdata), .o_done(bc_done), .o_rdata(bc_rdata),
        .o_fl_addr(o_fl_addr), .i_fl_data(i_fl_data),
        .o_fl_data(o_fl_data), .o_fl_data_oe(o_fl_data_oe),
        .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n),
        .o_fl_we_n(o_fl_we_n)
    );

    assign o_cmd_ready = (st_q == S_IDLE);

    // ==========================================================
    // Next state and outcome
    always_comb
    begin
        st_d = st_q;
        res_d = o_result;
        case (st_q)
            S_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    case (i_cmd)
                        fl_pkg::FL_CMD_WRITE: st_d = S_WR;
                        fl_pkg::FL_CMD_READ: st_d = S_RD;
                        fl_pkg::FL_CMD_POLL: st_d = S_P1;
                        default: st_d = i_skip_window ? S_E_WR : S_E_PRE;
                    endcase
                end
            end
            S_WR, S_RD, S_PDATA, S_RST:
            begin
                if (bc_done)
                begin
                    st_d = S_END;
                    res_d = (st_q == S_RST) ? fl_pkg::FL_RES_FAIL
                        : fl_pkg::FL_RES_OK;
                end
            end
            S_P1:
                if (bc_done)
                    st_d = S_P2;
            S_P2:
            begin
                if (bc_done)
                begin
                    if (tog_same)
                        st_d = S_PDATA;
                    else if (bc_rdata[`FL_BIT_FAIL])
                        st_d = S_P3;
                    else if (keep_q)
                        st_d = S_P1;
                    else
                    begin
                        st_d = S_END;
                        res_d = fl_pkg::FL_RES_BUSY;
                    end
                end
            end
            S_P3:
            begin
                if (bc_done)
                    st_d = tog_same ? S_PDATA : S_RST;
            end
            S_E_PRE:
            begin
                if (bc_done)
                begin
                    if (bc_rdata[`FL_BIT_WINDOW])
                    begin
                        st_d = S_END;
                        res_d = fl_pkg::FL_RES_REFUSED;
                    end
                    else
                        st_d = S_E_WR;
                end
            end
            S_E_WR:
                if (bc_done)
                    st_d = S_E_A;
            S_E_A:
                if (bc_done)
                    st_d = S_E_B;
            S_E_B:
            begin
                if (bc_done)
                begin
                    st_d = S_END;
                    if (tog_same)
                        res_d = fl_pkg::FL_RES_LOST;
                    else if (!skip_q && bc_rdata[`FL_BIT_WINDOW])
                        res_d = fl_pkg::FL_RES_LOST;
                    else
                        res_d = fl_pkg::FL_RES_OK;
                end
            end
            default:
                st_d = S_IDLE;
        endcase
    end

    // ==========================================================
    // State, cycle launch and outputs
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_q <= S_IDLE;
            go_q <= 1'b0;
            o_done <= 1'b0;
            o_result <= fl_pkg::FL_RES_OK;
            o_dev_busy <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            go_q <= (st_d != st_q) && (st_d != S_IDLE) && (st_d != S_END);
            o_done <= (st_q == S_END);
            o_result <= res_d;
            o_dev_busy <= !i_fl_ready_busy; // Inverted pin level, registered
        end
    end

    // Command capture and read data
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            addr_q <= 20'h00000;
            wdata_q <= 8'h00;
            keep_q <= 1'b0;
            skip_q <= 1'b0;
            first_q <= 8'h00;
            o_rdata <= 8'h00;
        end
        else
        begin
            if (st_q == S_IDLE && i_cmd_valid)
            begin
                addr_q <= i_addr;
                wdata_q <= i_wdata;
                keep_q <= i_keep_polling;
                skip_q <= i_skip_window;
            end
            if (bc_done && !cyc_wr)
            begin
                first_q <= bc_rdata;
                if (st_q == S_RD || st_q == S_PDATA)
                    o_rdata <= bc_rdata;
            end
        end
    end

    // ==========================================================
    // Assertion helpers: reads and events within one command
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rd_cnt_q <= 4'h0;
            rst_wr_q <= 1'b0;
            fail_seen_q <= 1'b0;
            pre_q <= 1'b0;
            is_poll_q <= 1'b0;
        end
        else if (st_q == S_IDLE)
        begin
            rd_cnt_q <= 4'h0;
            rst_wr_q <= 1'b0;
            fail_seen_q <= 1'b0;
            pre_q <= 1'b0;
            is_poll_q <= i_cmd == fl_pkg::FL_CMD_POLL;
        end
        else if (bc_done)
        begin
            if (!cyc_wr && rd_cnt_q != 4'hf)
                rd_cnt_q <= rd_cnt_q + 4'h1;
            if (st_q == S_RST)
                rst_wr_q <= 1'b1;
            if (st_q == S_P2 && bc_rdata[`FL_BIT_FAIL])
                fail_seen_q <= 1'b1;
            if (st_q == S_E_PRE)
                pre_q <= 1'b1;
        end
    end

    // ==========================================================
    // Assertions
    AST_DOUBLE_READ: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (st_q == S_END && is_poll_q) |-> rd_cnt_q >= 4'h2)
        else $error("poll decided before two reads");
    AST_DATA_AFTER: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (st_q == S_P2 && bc_done && tog_same) |=> st_q == S_PDATA && go_q)
        else $error("no array read after steady toggle");
    AST_RECHECK: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (st_q == S_P3) |-> fail_seen_q)
        else $error("recheck without fail bit");
    AST_FAIL_RESET: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (o_done && o_result == fl_pkg::FL_RES_FAIL) |-> $past(rst_wr_q))
        else $error("failure reported without reset write");
    AST_RESTART: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (st_q == S_P2 && bc_done && !tog_same &&
         !bc_rdata[`FL_BIT_FAIL] && keep_q) |=> st_q == S_P1 && go_q)
        else $error("poll loop skipped first double read");
    AST_CONFIRM: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (st_q == S_E_B && bc_done) |-> rd_cnt_q >= 4'h1)
        else $error("window judged before toggle confirmation");
    AST_PRE_CHECK: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (go_q && st_q == S_E_WR && !skip_q) |-> pre_q)
        else $error("sector add without prior window read");
    AST_VALID_ADDR: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (!o_fl_oe_n && st_q != S_IDLE) |-> o_fl_addr == addr_q)
        else $error("status read at wrong address");
    AST_DONE_PULSE: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_done |=> !o_done && o_cmd_ready)
        else $error("done not a single pulse");

endmodule : fl_poll_host

// *** verif/fl_dev_model.sv ***
// Behavioural byte-wide flash device that answers status reads
`timescale 1ns/1ns
`include "fl_consts.svh"

module fl_dev_model #(
    parameter int BUSY_READS = 4,
    parameter int WIN_READS = 6,
    parameter int ERASE_READS = 8,
    parameter logic [7:0] SECT_CMD = 8'h30
) (
    // Flash pins
    input wire logic [19:0] i_fl_addr,
    input wire logic [7:0] i_fl_data,
    input wire logic i_fl_ce_n,
    input wire logic i_fl_oe_n,
    input wire logic i_fl_we_n,
    output logic [7:0] o_fl_data,
    output logic o_fl_ready_busy
);
    localparam int M_ARRAY = 0;
    localparam int M_PROG = 1;
    localparam int M_WIN = 2;
    localparam int M_ERASE = 3;
    logic [7:0] mem [16];
    logic [7:0] want;
    logic [7:0] wd;
    logic [7:0] dq = 8'h00;
    logic [3:0] wa;
    logic wsel = 1'b0;
    logic fail = 1'b0;
    logic tog = 1'b0;
    int mode = M_ARRAY;
    int cnt = 0;
    int resets = 0;

    // Erased array at start
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hff;
    end

    // Write data follows the bus while the write strobe is low
    always @(*)
    begin
        if (!i_fl_we_n) wd = i_fl_data;
    end

    // Select and address caught as the write strobe falls
    always @(negedge i_fl_we_n)
    begin
        wsel = !i_fl_ce_n;
        wa = i_fl_addr[3:0];
    end

    // Command decode at the end of a write; erase ignores all
    always @(posedge i_fl_we_n)
    begin
        if (wsel && mode != M_ERASE)
        begin
            if (wd == `FL_RESET_CMD)
            begin
                mode = M_ARRAY;
                fail = 1'b0;
                resets++;
            end
            else if (wd == SECT_CMD && mode != M_PROG)
            begin
                mode = M_WIN;
                cnt = 0;
            end
            else if (mode == M_ARRAY)
            begin
                want = wd;
                fail = (wd & ~mem[wa]) != 8'h00;
                mode = M_PROG;
                cnt = 0;
            end
        end
    end

    // Status or array byte per read, progress counted in reads
    always @(negedge i_fl_oe_n)
    begin
        if (!i_fl_ce_n)
        begin
            tog = ~tog;
            cnt++;
            if (mode == M_PROG)
                dq = {~want[7], tog, fail && cnt >= BUSY_READS, 5'h00};
            else if (mode == M_ARRAY)
                dq = mem[i_fl_addr[3:0]];
            else
                dq = {2'b01 & {1'b0, tog}, 1'b0, 1'b0, mode == M_ERASE, tog, 2'b00};
            if (mode == M_PROG && !fail && cnt >= BUSY_READS)
            begin
                mem[wa] = want;
                mode = M_ARRAY;
            end
            if (mode == M_WIN && cnt >= WIN_READS)
            begin
                mode = M_ERASE;
                cnt = 0;
            end
            if (mode == M_ERASE && cnt >= ERASE_READS)
            begin
                foreach (mem[i]) mem[i] = 8'hff;
                mode = M_ARRAY;
            end
        end
    end

    // Undriven bus shows inverted last byte; busy pin driven high only in array mode
    assign o_fl_data = (!i_fl_ce_n && !i_fl_oe_n) ? dq : ~dq;
    assign o_fl_ready_busy = (mode == M_ARRAY);

endmodule : fl_dev_model

// *** verif/fl_poll_host_tb_top.sv ***
// Testbench for the flash host with a device model
`timescale 1ns/1ns

module fl_poll_host_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic i_cmd_valid = 1'b0;
    fl_pkg::fl_cmd_t i_cmd = fl_pkg::FL_CMD_READ;
    logic [19:0] i_addr = 20'h00000;
    logic [7:0] i_wdata = 8'h00;
    logic i_keep_polling = 1'b0;
    logic i_skip_window = 1'b0;
    logic o_cmd_ready;
    logic o_done;
    fl_pkg::fl_res_t o_result;
    logic [7:0] o_rdata;
    logic o_dev_busy;
    logic [19:0] fl_addr;
    logic [7:0] host_data;
    logic [7:0] dev_data;
    logic [7:0] bus;
    logic data_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic ready_busy;
    fl_pkg::fl_res_t res;
    logic [7:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    localparam logic [7:0] SECT = 8'h30;

    // Clock
    always #2 i_clk_sys = ~i_clk_sys;

    // Data wire level from both drivers
    assign bus = data_oe ? host_data : dev_data;

    fl_poll_host u_fl_poll_host (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_keep_polling(i_keep_polling),
        .i_skip_window(i_skip_window), .o_cmd_ready(o_cmd_ready),
        .o_done(o_done), .o_result(o_result), .o_rdata(o_rdata),
        .o_dev_busy(o_dev_busy), .o_fl_addr(fl_addr), .i_fl_data(bus),
        .o_fl_data(host_data), .o_fl_data_oe(data_oe), .o_fl_ce_n(ce_n),
        .o_fl_oe_n(oe_n), .o_fl_we_n(we_n), .i_fl_ready_busy(ready_busy)
    );

    fl_dev_model #(.SECT_CMD(SECT)) u_fl_dev_model (
        .i_fl_addr(fl_addr), .i_fl_data(bus), .i_fl_ce_n(ce_n),
        .i_fl_oe_n(oe_n), .i_fl_we_n(we_n), .o_fl_data(dev_data),
        .o_fl_ready_busy(ready_busy)
    );

    // Closing report
    task automatic give_verdict;
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // One user command, result and byte kept for the compares
    task automatic do_cmd(input fl_pkg::fl_cmd_t c, input logic [19:0] a,
        input logic [7:0] d, input logic keep, input logic skip);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_addr <= a;
        i_wdata <= d;
        i_keep_polling <= keep;
        i_skip_window <= skip;
        @(negedge i_clk_sys);
        while (o_cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 100)
        begin
            $display("FAIL %0t command never taken", $time);
            err_total++;
            give_verdict();
        end
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b0;
        n = 0;
        @(negedge i_clk_sys);
        while (o_done !== 1'b1 && n < 5000)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 5000)
        begin
            $display("FAIL %0t command never finished", $time);
            err_total++;
            give_verdict();
        end
        res = o_result;
        rd = o_rdata;
    endtask : do_cmd

    // Result code compare
    task automatic chk_res(input fl_pkg::fl_res_t got,
        input fl_pkg::fl_res_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("FAIL %0t result %0d want %0d", $time, got, exp);
            err_total++;
        end
    endtask : chk_res

    // Byte compare
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("FAIL %0t byte %h want %h", $time, got, exp);
            err_total++;
        end
    endtask : chk_byte

    // Main sequence
    initial
    begin
        repeat (3) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        do_cmd(fl_pkg::FL_CMD_READ, 20'h00000, 8'h00, 1'b0, 1'b0);
        chk_byte(rd, 8'hff);
        do_cmd(fl_pkg::FL_CMD_WRITE, 20'h00001, 8'h5a, 1'b0, 1'b0);
        chk_byte({7'h00, o_dev_busy}, 8'h01);
        do_cmd(fl_pkg::FL_CMD_POLL, 20'h00001, 8'h00, 1'b0, 1'b0);
        chk_res(res, fl_pkg::FL_RES_BUSY);
        do_cmd(fl_pkg::FL_CMD_POLL, 20'h00001, 8'h00, 1'b1, 1'b0);
        chk_res(res, fl_pkg::FL_RES_OK);
        chk_byte(rd, 8'h5a);
        // Program ones over zeros
        do_cmd(fl_pkg::FL_CMD_WRITE, 20'h00001, 8'ha5, 1'b0, 1'b0);
        do_cmd(fl_pkg::FL_CMD_POLL, 20'h00001, 8'h00, 1'b1, 1'b0);
        chk_res(res, fl_pkg::FL_RES_FAIL);
        chk_byte(8'(u_fl_dev_model.resets), 8'h01);
        do_cmd(fl_pkg::FL_CMD_READ, 20'h00001, 8'h00, 1'b0, 1'b0);
        chk_byte(rd, 8'h5a);
        // Sector adds inside the window, then after it closes
        do_cmd(fl_pkg::FL_CMD_ERASE_ADD, 20'h00002, SECT, 1'b0, 1'b1);
        chk_res(res, fl_pkg::FL_RES_OK);
        do_cmd(fl_pkg::FL_CMD_ERASE_ADD, 20'h00003, SECT, 1'b0, 1'b0);
        chk_res(res, fl_pkg::FL_RES_OK);
        do_cmd(fl_pkg::FL_CMD_POLL, 20'h00002, 8'h00, 1'b0, 1'b0);
        chk_res(res, fl_pkg::FL_RES_BUSY);
        do_cmd(fl_pkg::FL_CMD_POLL, 20'h00002, 8'h00, 1'b0, 1'b0);
        chk_res(res, fl_pkg::FL_RES_BUSY);
        do_cmd(fl_pkg::FL_CMD_ERASE_ADD, 20'h00004, SECT, 1'b0, 1'b0);
        chk_res(res, fl_pkg::FL_RES_REFUSED);
        do_cmd(fl_pkg::FL_CMD_POLL, 20'h00002, 8'h00, 1'b1, 1'b0);
        chk_res(res, fl_pkg::FL_RES_OK);
        chk_byte(rd, 8'hff);
        chk_byte({7'h00, o_dev_busy}, 8'h00);
        do_cmd(fl_pkg::FL_CMD_READ, 20'h00001, 8'h00, 1'b0, 1'b0);
        chk_byte(rd, 8'hff);
        // Reset byte in place of a sector add: no toggle, not accepted
        do_cmd(fl_pkg::FL_CMD_ERASE_ADD, 20'h00003, 8'hf0, 1'b0, 1'b1);
        chk_res(res, fl_pkg::FL_RES_LOST);
        give_verdict();
    end

endmodule : fl_poll_host_tb_top
